//--- pkg/adcc_pkg.sv
// constants for the converter control block: register map, field layout, reset values, timing
// assumes a 20 MHz system clock and a 32-bit register bus with byte addresses
package adcc_pkg;
	localparam int ADDR_W = 8;
	localparam int RES_W = 12;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CSR_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CSR_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RES_LOW = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CMP_HIGH = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CMP_LOW = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h18;
	// control_status_one fields
	localparam int BIT_COMPLETE = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_CONT_EN = 5;
	localparam int CH_MSB = 4;
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [4:0] CH_RESERVED = 5'h1c;
	localparam logic [4:0] CH_REF_HIGH = 5'h1d;
	localparam logic [4:0] CH_REF_LOW = 5'h1e;
	// control_status_two fields
	localparam int BIT_ACTIVE = 7;
	localparam int BIT_TRIG_SEL = 6;
	localparam int BIT_CMP_EN = 5;
	localparam int BIT_CMP_GE = 4;
	// config fields, resolution code at bits 3:2
	localparam int MODE_LSB = 2;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_12 = 2'h1;
	localparam logic [1:0] MODE_10 = 2'h2;
	// reset values
	localparam logic [4:0] RST_CH = 5'h1f;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [11:0] RST_CMP = 12'h000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// sampling window ahead of the bit trials
	localparam int CLK_HZ = 20000000;
	localparam int SAMPLE_TIME_NS = 200;
	localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	typedef enum logic [1:0] {
		ADCC_IDLE = 2'b00,
		ADCC_SAMPLE = 2'b01,
		ADCC_TRIAL = 2'b10
	} adcc_state_t;
endpackage : adcc_pkg

//--- pkg/adcc_sar_if.sv
// link between the control logic and the successive-approximation sequencer
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface adcc_sar_if;
	logic start;
	logic abort;
	logic [1:0] mode;
	logic busy;
	logic done;
	logic [11:0] result;
	modport ctl (output start, output abort, output mode, input busy, input done, input result);
	modport sar (input start, input abort, input mode, output busy, output done, output result);
endinterface : adcc_sar_if

//--- testbench/adcc_top_assertions.sv
// port-level checker for the converter control block
// assumes it is bound into adcc_top and sees only that module's ports
`timescale 1ns/10ps
module adcc_checker
	import adcc_pkg::*;
#(
	parameter int NUM_INPUTS = 28
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // synchronous reset
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NUM_INPUTS-1:0] input_sel, // input select
	input wire logic high_reference_sel, // high reference select
	input wire logic low_reference_sel, // low reference select
	input wire logic converter_on, // analog core powered
	input wire logic complete_irq // complete interrupt
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	b_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	b_timing_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	r_timing_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	sel_onehot_a: assert property (
		$onehot0({input_sel, high_reference_sel, low_reference_sel}))
		else $error("more than one input routed");
	irq_clear_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_RES_LOW && !converter_on
		|-> ##[1:3] !complete_irq)
		else $error("interrupt kept after result low read");
	reset_quiet_a: assert property (disable iff (1'b0)
		rst |=> !s_axi_bvalid && !s_axi_rvalid && !complete_irq)
		else $error("outputs active after reset");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(complete_irq));
endmodule : adcc_checker

bind adcc_top adcc_checker #(.NUM_INPUTS(NUM_INPUTS)) u_adcc_checker (
	.sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .input_sel(input_sel),
	.high_reference_sel(high_reference_sel), .low_reference_sel(low_reference_sel),
	.converter_on(converter_on), .complete_irq(complete_irq)
);

//--- testbench/adcc_top_bench.sv
// self-checking bench for the converter control block over axi4-lite
// assumes a constant comparator level during a conversion, so results are all ones or all zeros
`timescale 1ns/10ps
module adcc_top_bench import adcc_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic hw_trigger_in = 1'b0, comp_in = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, high_sel, low_sel, conv_on, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [RES_W-1:0] dac_code;
	logic [27:0] input_sel;
	int err_count = 0, comparisons = 0, cyc = 0;
	logic [4:0] codes [5] = '{5'h00, 5'h05, 5'h1b, 5'h1d, 5'h1e};

	adcc_top #(.NUM_INPUTS(28)) u_adcc_top (
		.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.hw_trigger_in(hw_trigger_in), .comp_in(comp_in), .dac_code(dac_code),
		.input_sel(input_sel), .high_reference_sel(high_sel), .low_reference_sel(low_sel),
		.converter_on(conv_on), .complete_irq(irq)
	);
	initial forever #25 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// ready is looked at on the falling edge so the handshake edge is known in advance;
	// responses are accepted one cycle late so the response-hold checks see a stall
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ad = 1'b0;
		logic wd = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge sys_clk);
			ad = ad || awready;
			wd = wd || wready;
			@(posedge sys_clk);
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(negedge sys_clk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge sys_clk);
		bready <= 1'b1;
		@(posedge sys_clk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge sys_clk); while (arready !== 1'b1);
		@(posedge sys_clk);
		arvalid <= 1'b0;
		do @(negedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge sys_clk);
		rready <= 1'b1;
		@(posedge sys_clk);
		rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, e, d);
	endtask : rc
	// polling control_status_one leaves the flag untouched
	task automatic wait_done();
		d = 32'h0;
		for (int i = 0; i < 30 && d[7] !== 1'b1; i++) rd(OFS_CSR_ONE);
		chk("complete flag", 32'h1, {31'h0, d[7]});
	endtask : wait_done
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rc(OFS_CSR_ONE, {27'h0, RST_CH}, "csr one reset");
		rc(OFS_CSR_TWO, 32'h0, "csr two reset");
		rc(8'h1c, 32'h0, "unmapped data");
		chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(8'h1c, 8'hff);
		chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		$display("test bus done");
		foreach (codes[i]) begin
			wr(OFS_CSR_ONE, {3'b010, codes[i]});
			wait_done();
			chk("input sel", codes[i] < 28 ? 32'h1 << codes[i] : 32'h0, {4'h0, input_sel});
			chk("ref sel", {codes[i] == CH_REF_HIGH, codes[i] == CH_REF_LOW}, {high_sel, low_sel});
			chk("irq", 32'h1, {31'h0, irq});
			chk("dac code", 32'hff, {20'h0, dac_code});
			rc(OFS_RES_LOW, 32'hff, "result low");
			rc(OFS_CSR_ONE, {24'h0, 3'b010, codes[i]}, "flag cleared");
			rc(OFS_CSR_TWO, 32'h0, "idle after single");
			chk("converter on", 32'h0, {31'h0, conv_on});
		end
		comp_in <= 1'b0;
		wr(OFS_CSR_ONE, 8'h03);
		wait_done();
		chk("masked irq", 32'h0, {31'h0, irq});
		rc(OFS_RES_LOW, 32'h0, "result zero");
		comp_in <= 1'b1;
		$display("test channels done");
		wr(OFS_CMP_LOW, 8'h80);
		wr(OFS_CSR_TWO, 8'h20);
		wr(OFS_CSR_ONE, 8'h01);
		repeat (40) @(posedge sys_clk);
		rc(OFS_CSR_ONE, 32'h01, "compare miss flag");
		rc(OFS_RES_LOW, 32'h0, "compare miss result");
		wr(OFS_CSR_TWO, 8'h30);
		wr(OFS_CSR_ONE, 8'h01);
		wait_done();
		rc(OFS_RES_LOW, 32'h7f, "compare hit result");
		$display("test compare done");
		wr(OFS_CSR_TWO, 8'h40);
		wr(OFS_CSR_ONE, 8'h02);
		repeat (40) @(posedge sys_clk);
		rc(OFS_CSR_ONE, 32'h02, "no soft start");
		hw_trigger_in <= 1'b1;
		@(posedge sys_clk);
		hw_trigger_in <= 1'b0;
		wait_done();
		rc(OFS_RES_LOW, 32'hff, "hw result");
		repeat (40) @(posedge sys_clk);
		rc(OFS_CSR_ONE, 32'h02, "one per trigger");
		$display("test hw trigger done");
		wr(OFS_CSR_TWO, 8'h00);
		wr(OFS_CSR_ONE, 8'h22);
		wait_done();
		rd(OFS_RES_LOW);
		wait_done();
		wr(OFS_CSR_ONE, 8'h3f);
		repeat (40) @(posedge sys_clk);
		rc(OFS_CSR_ONE, 32'h3f, "stopped no flag");
		rc(OFS_CSR_TWO, 32'h0, "stopped idle");
		chk("converter off", 32'h0, {31'h0, conv_on});
		$display("test continuous done");
		comp_in <= 1'b0;
		wr(OFS_CSR_ONE, 8'h04);
		rc(OFS_CSR_TWO, 32'h80, "active");
		chk("converter busy", 32'h1, {31'h0, conv_on});
		wr(OFS_CSR_ONE, 8'h1f);
		repeat (40) @(posedge sys_clk);
		rc(OFS_CSR_ONE, 32'h1f, "aborted no flag");
		rc(OFS_CSR_TWO, 32'h0, "aborted idle");
		rc(OFS_RES_LOW, 32'hff, "aborted result kept");
		$display("test abort done");
		wr(OFS_CONFIG, 8'h04);
		comp_in <= 1'b1;
		wr(OFS_CSR_ONE, 8'h06);
		wait_done();
		rc(OFS_RES_HIGH, 32'hf, "high twelve");
		comp_in <= 1'b0;
		wr(OFS_CSR_ONE, 8'h06);
		wait_done();
		rc(OFS_RES_LOW, 32'hff, "locked low");
		wr(OFS_CONFIG, 8'h08);
		comp_in <= 1'b1;
		wr(OFS_CSR_ONE, 8'h06);
		wait_done();
		rc(OFS_RES_HIGH, 32'h3, "high ten");
		rc(OFS_RES_LOW, 32'hff, "low ten");
		$display("test resolution done");
		end_sim();
	end
endmodule : adcc_top_bench

//--- verilog/adcc_sar.sv
// successive-approximation sequencer: sample window, then one bit trial per clock
// assumes an analog comparator answers within one clock of each trial code
`timescale 1ns/10ps
module adcc_sar
	import adcc_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	adcc_sar_if.sar link, // control side
	input wire logic comp_in, // 1 when input at or above trial code
	output logic [RES_W-1:0] dac_code // trial code to the analog core
);
	adcc_state_t state_r;
	logic [3:0] cnt_r;
	logic [3:0] msb;
	logic [RES_W-1:0] trial_r;
	logic [RES_W-1:0] bit_mask;
	logic done_r;

	always_comb begin
		case (link.mode)
			MODE_12: msb = 4'd11;
			MODE_10: msb = 4'd9;
			default: msb = 4'd7;
		endcase
		bit_mask = RES_W'(1) << cnt_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// abort drops partial trial state outright, start wins over it in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ADCC_IDLE;
			cnt_r <= 4'h0;
			trial_r <= 12'h000;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (link.abort || link.start) begin
				state_r <= link.start ? ADCC_SAMPLE : ADCC_IDLE;
				cnt_r <= 4'(SAMPLE_CYCLES - 1);
				trial_r <= 12'h000;
			end else begin
				case (state_r)
					ADCC_SAMPLE: begin
						if (cnt_r == 4'h0) begin
							state_r <= ADCC_TRIAL;
							cnt_r <= msb;
							trial_r <= RES_W'(1) << msb;
						end else begin
							cnt_r <= cnt_r - 4'h1;
						end
					end
					ADCC_TRIAL: begin
						if (!comp_in)
							trial_r <= trial_r & ~bit_mask;
						if (cnt_r == 4'h0) begin
							state_r <= ADCC_IDLE;
							done_r <= 1'b1;
						end else begin
							cnt_r <= cnt_r - 4'h1;
							trial_r <= (comp_in ? trial_r : (trial_r & ~bit_mask)) | (bit_mask >> 1);
						end
					end
					default: state_r <= ADCC_IDLE;
				endcase
			end
		end
	end

	assign dac_code = trial_r;
	assign link.busy = (state_r != ADCC_IDLE);
	assign link.done = done_r;
	assign link.result = trial_r;
endmodule : adcc_sar

//--- verilog/adcc_top.sv
// converter control block: axi4-lite registers, start/abort, compare, result interlock
// assumes synchronous inputs, an external comparator on comp_in and a pulsed hw trigger
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Function
// - control write aborts, restarts unless channel off or hardware trigger selected
// - compare off: complete flag every conversion
// - compare on: flag only when condition true
// - flag cleared by control write, low read
// - interrupt is flag gated by enable bit
// - continuous off: one conversion per start
// - continuous on: repeat after start event
// - five-bit channel field selects input
// - all-ones channel disables, stops continuous
// - single conversion returns to idle itself
// - active bit spans start to end/abort
// - trigger select: write or hardware trigger
// - compare enable bit turns compare on
// - direction bit: less-than or greater-equal
// - mux routes up to 28 inputs
// - results update except failed compare
// - compare hit stores result minus compare
// - at 10 and 12 bits, high read locks results until low read
module adcc_top
	import adcc_pkg::*;
#(
	parameter int NUM_INPUTS = 28
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic hw_trigger_in, // hardware trigger pulse
	input wire logic comp_in, // analog comparator decision
	output logic [RES_W-1:0] dac_code, // trial code to the analog core
	output logic [NUM_INPUTS-1:0] input_sel, // one-hot analog input select
	output logic high_reference_sel, // route high reference
	output logic low_reference_sel, // route low reference
	output logic converter_on, // analog core powered
	output logic complete_irq // conversion complete interrupt
);
	adcc_sar_if sar_link ();

	// register state
	logic [4:0] channel_select_r;
	logic complete_irq_enable_r;
	logic continuous_enable_r;
	logic conversion_complete_flag_r;
	logic trigger_select_r;
	logic compare_enable_r;
	logic compare_greater_equal_r;
	logic [RES_W-1:0] compare_value_r;
	logic [1:0] mode_r;
	logic [RES_W-1:0] result_r;
	logic lock_r;
	logic cont_run_r;
	logic trig_prev_r;

	// bus state
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	logic do_wr;
	logic do_rd;
	logic wr_byte;
	logic wr_csr_one;
	logic wr_go;
	logic sw_start;
	logic hw_event;
	logic conv_done;
	logic [RES_W:0] diff;
	logic cmp_hit;
	logic take_result;
	logic [RES_W-1:0] res_mask;
	logic [RES_W-1:0] stored;
	logic rd_high;
	logic rd_low;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_ok;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite handshakes: address and data may arrive in either order
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign do_wr = aw_held_r && w_held_r;
	assign do_rd = s_axi_arvalid && !rvalid_r;
	assign wr_byte = do_wr && wstrb_r[0];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		if (waddr_r[ADDR_W-1:2] == OFS_CSR_ONE[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_CSR_TWO[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_RES_HIGH[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_RES_LOW[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_CMP_HIGH[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_CMP_LOW[ADDR_W-1:2]) wr_ok = 1'b1;
		else if (waddr_r[ADDR_W-1:2] == OFS_CONFIG[ADDR_W-1:2]) wr_ok = 1'b1;
		else wr_ok = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// start, abort and continuous sequencing
	assign wr_csr_one = wr_byte && (waddr_r[ADDR_W-1:2] == OFS_CSR_ONE[ADDR_W-1:2]);
	assign wr_go = wr_csr_one && (wdata_r[CH_MSB:0] != CH_OFF);
	assign sw_start = wr_go && !trigger_select_r;
	// a trigger pulse that lands mid-conversion is dropped rather than restarting it
	assign hw_event = hw_trigger_in && !trig_prev_r && trigger_select_r && !wr_csr_one
		&& (channel_select_r != CH_OFF) && !sar_link.busy;
	assign conv_done = sar_link.done && !wr_csr_one;

	assign sar_link.abort = wr_csr_one;
	assign sar_link.start = sw_start || hw_event || (conv_done && cont_run_r);
	assign sar_link.mode = mode_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trig_prev_r <= 1'b0;
			cont_run_r <= 1'b0;
		end else begin
			trig_prev_r <= hw_trigger_in;
			if (wr_csr_one)
				cont_run_r <= sw_start && wdata_r[BIT_CONT_EN];
			else if (hw_event)
				cont_run_r <= continuous_enable_r;
			else if (!continuous_enable_r)
				cont_run_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare and result transfer
	always_comb begin
		case (mode_r)
			MODE_12: res_mask = 12'hfff;
			MODE_10: res_mask = 12'h3ff;
			default: res_mask = 12'h0ff;
		endcase
	end
	assign diff = {1'b0, sar_link.result & res_mask} - {1'b0, compare_value_r & res_mask};
	assign cmp_hit = compare_greater_equal_r ? !diff[RES_W] : diff[RES_W];
	assign take_result = conv_done && (!compare_enable_r || cmp_hit);
	assign stored = compare_enable_r ? (diff[RES_W-1:0] & res_mask)
		: (sar_link.result & res_mask);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			result_r <= 12'h000;
		end else if (take_result && !lock_r) begin
			result_r <= stored;
		end
	end

	// the interlock is skipped only for MODE_8; the unused mode code 3 converts at 8 bits and still locks
	always_ff @(posedge sys_clk) begin
		if (rst)
			lock_r <= 1'b0;
		else if (rd_low)
			lock_r <= 1'b0;
		else if (rd_high && mode_r != MODE_8)
			lock_r <= 1'b1;
	end

	// a completion in the same cycle as a low read keeps the flag set
	always_ff @(posedge sys_clk) begin
		if (rst)
			conversion_complete_flag_r <= 1'b0;
		else if (take_result)
			conversion_complete_flag_r <= 1'b1;
		else if (wr_csr_one || rd_low)
			conversion_complete_flag_r <= 1'b0;
	end

	assign complete_irq = conversion_complete_flag_r && complete_irq_enable_r;

	////////////////////////////////////////////////////////////////////////////////
	// software-written control fields
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			channel_select_r <= RST_CH;
			complete_irq_enable_r <= 1'b0;
			continuous_enable_r <= 1'b0;
			trigger_select_r <= 1'b0;
			compare_enable_r <= 1'b0;
			compare_greater_equal_r <= 1'b0;
			compare_value_r <= RST_CMP;
			mode_r <= RST_MODE;
		end else if (wr_byte) begin
			if (waddr_r[ADDR_W-1:2] == OFS_CSR_ONE[ADDR_W-1:2]) begin
				channel_select_r <= wdata_r[CH_MSB:0];
				complete_irq_enable_r <= wdata_r[BIT_IRQ_EN];
				continuous_enable_r <= wdata_r[BIT_CONT_EN];
			end else if (waddr_r[ADDR_W-1:2] == OFS_CSR_TWO[ADDR_W-1:2]) begin
				trigger_select_r <= wdata_r[BIT_TRIG_SEL];
				compare_enable_r <= wdata_r[BIT_CMP_EN];
				compare_greater_equal_r <= wdata_r[BIT_CMP_GE];
			end else if (waddr_r[ADDR_W-1:2] == OFS_CMP_HIGH[ADDR_W-1:2]) begin
				compare_value_r[11:8] <= wdata_r[3:0];
			end else if (waddr_r[ADDR_W-1:2] == OFS_CMP_LOW[ADDR_W-1:2]) begin
				compare_value_r[7:0] <= wdata_r[7:0];
			end else if (waddr_r[ADDR_W-1:2] == OFS_CONFIG[ADDR_W-1:2]) begin
				mode_r <= wdata_r[MODE_LSB+1:MODE_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog routing; reserved codes still convert whatever the mux presents
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			high_reference_sel <= 1'b0;
			low_reference_sel <= 1'b0;
			converter_on <= 1'b0;
		end else begin
			high_reference_sel <= (channel_select_r == CH_REF_HIGH);
			low_reference_sel <= (channel_select_r == CH_REF_LOW);
			converter_on <= (channel_select_r != CH_OFF) && sar_link.busy;
		end
	end

	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_mux
		always_ff @(posedge sys_clk) begin
			if (rst)
				input_sel[i] <= 1'b0;
			else
				input_sel[i] <= (channel_select_r == 5'(i));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path with side effects taken at address acceptance
	assign rd_high = do_rd && (s_axi_araddr[ADDR_W-1:2] == OFS_RES_HIGH[ADDR_W-1:2]);
	assign rd_low = do_rd && (s_axi_araddr[ADDR_W-1:2] == OFS_RES_LOW[ADDR_W-1:2]);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr[ADDR_W-1:2] == OFS_CSR_ONE[ADDR_W-1:2])
			rd_word[7:0] = {conversion_complete_flag_r, complete_irq_enable_r,
				continuous_enable_r, channel_select_r};
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_CSR_TWO[ADDR_W-1:2])
			rd_word[7:0] = {sar_link.busy, trigger_select_r, compare_enable_r,
				compare_greater_equal_r, 4'h0};
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_RES_HIGH[ADDR_W-1:2])
			rd_word[3:0] = result_r[11:8];
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_RES_LOW[ADDR_W-1:2])
			rd_word[7:0] = result_r[7:0];
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_CMP_HIGH[ADDR_W-1:2])
			rd_word[3:0] = compare_value_r[11:8];
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_CMP_LOW[ADDR_W-1:2])
			rd_word[7:0] = compare_value_r[7:0];
		else if (s_axi_araddr[ADDR_W-1:2] == OFS_CONFIG[ADDR_W-1:2])
			rd_word[MODE_LSB+1:MODE_LSB] = mode_r;
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else if (do_rd) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	adcc_sar u_sar (
		.sys_clk(sys_clk),
		.rst(rst),
		.link(sar_link),
		.comp_in(comp_in),
		.dac_code(dac_code)
	);
endmodule : adcc_top
